// file: verification/tb_standby_wakeup_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module tb_standby_wakeup_watchdog;
	// ****************************
	// Signals and case table
	// ****************************
	typedef struct packed {
		logic [31:0] n;
		logic        sb;
	} row_s;
	logic               core_clk    = 1'b0;
	logic               rstn        = 1'b0;
	wdt_pkg::wdt_ctrl_s ctrl        = '0;
	logic [31:0]        reload      = 32'h0000_0002;
	wdt_pkg::wdt_stat_s stat;
	logic [31:0]        count;
	int                 n_fail      = 0;
	int                 check_count = 0;
	int                 k;
	row_s               rows [3]    = '{'{32'h2, 1'b0}, '{32'h3, 1'b1},
		'{32'h5, 1'b0}};

	standby_wakeup_watchdog i_standby_wakeup_watchdog (
		.core_clk              (core_clk),
		.rstn                  (rstn),
		.ctrl                  (ctrl),
		.reload_value_register (reload),
		.stat                  (stat),
		.count                 (count)
	);

	// A 40 ns clock.
	always #20 core_clk = ~core_clk;

	// ****************************
	// Shared tasks
	// ****************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// Ticks come about every 763 cycles, so a bound of 900 is ample.
	task automatic wait_tick;
		logic [31:0] c;
		int          i;
		c = count;
		for (i = 0; i < 900 && count === c; i++) begin
			@(negedge core_clk);
		end
		if (count === c) begin
			n_fail++;
			$display("Error at %0t: no tick seen", $time);
			test_done;
		end
	endtask : wait_tick

	// Controls change only just after a rising edge.
	task automatic drive(input logic en, fr, cl, sb);
		@(posedge core_clk);
		ctrl <= '{en, fr, cl, sb};
	endtask : drive

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		repeat (6) @(posedge core_clk);
		chk({28'h0, stat}, 32'h0);
		chk(count, 32'h0);
		rstn <= 1'b1;
		$display("test reset done");
		// Each row: idle with a clear, enable, count down, expire.
		foreach (rows[r]) begin
			drive(1'b0, 1'b0, 1'b0, rows[r].sb);
			reload <= rows[r].n;
			drive(1'b0, 1'b0, 1'b0, rows[r].sb);
			drive(1'b0, 1'b0, 1'b1, rows[r].sb);
			drive(1'b1, 1'b0, 1'b0, rows[r].sb);
			@(negedge core_clk);
			chk({31'h0, stat.status_flag}, 32'h0);
			chk(count, rows[r].n);
			for (k = 1; k < rows[r].n; k++) begin
				wait_tick;
				chk(count, 32'(rows[r].n - k));
			end
			wait_tick;
			chk(count, rows[r].n);
			chk({28'h0, stat}, {28'h0, 2'b11, rows[r].sb, 1'b0});
			$display("test row %0d done", r);
		end
		// The flag is left pending; a forced reload restarts the interval.
		repeat (5) @(negedge core_clk);
		chk({31'h0, stat.irq}, 32'h1);
		wait_tick;
		drive(1'b1, 1'b1, 1'b0, 1'b0);
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		@(negedge core_clk);
		chk(count, 32'h5);
		// The second expiry with the flag still set asks for a reset.
		repeat (5) wait_tick;
		chk({28'h0, stat}, 32'hd);
		@(negedge core_clk);
		chk({31'h0, stat.reset_req}, 32'h0);
		drive(1'b1, 1'b0, 1'b1, 1'b0);
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		@(negedge core_clk);
		chk({30'h0, stat.irq, stat.status_flag}, 32'h0);
		$display("test reload and reset request done");
		// Disabled, nothing counts or expires even over two ticks.
		drive(1'b0, 1'b0, 1'b0, 1'b1);
		reload <= 32'h0000_0001;
		repeat (1700) @(negedge core_clk);
		chk(count, 32'h1);
		chk({28'h0, stat}, 32'h0);
		// A reset in mid-run clears everything at once.
		drive(1'b1, 1'b0, 1'b0, 1'b1);
		repeat (1700) @(negedge core_clk);
		chk({31'h0, stat.status_flag}, 32'h1);
		rstn <= 1'b0;
		@(negedge core_clk);
		chk({28'h0, stat}, 32'h0);
		chk(count, 32'h0);
		// Release again: the first edge loads the reload value, then it holds.
		@(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) begin
			@(posedge core_clk);
			@(negedge core_clk);
			chk(count, 32'h1);
			chk({28'h0, stat}, 32'h0);
		end
		$display("test idle and second reset done");
		test_done;
	end
endmodule : tb_standby_wakeup_watchdog

`default_nettype wire

// file: verilog/lsclk_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

module lsclk_tick_gen #(
	parameter int CORE_HZ = `WDT_CORE_HZ,
	parameter int TICK_HZ = `WDT_LSCLK_HZ,
	parameter int ACC_W   = `WDT_ACC_W
) (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic rstn,
	// One-cycle enable at the low-speed rate.
	output var  logic tick
);

	// ***************************************************************
	// Fractional divider
	// ***************************************************************
	localparam logic [ACC_W-1:0] STEP  = ACC_W'(TICK_HZ);
	localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CORE_HZ);

	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;

	// The phase accumulator keeps the long-run average exact, at the
	// cost of one core cycle of jitter on each tick.
	always_comb begin
		next_acc = acc + STEP;
	end

	// Accumulate and wrap, pulsing tick on each wrap.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc  <= '0;
			tick <= 1'b0;
		end else if (next_acc >= LIMIT) begin
			acc  <= next_acc - LIMIT;
			tick <= 1'b1;
		end else begin
			acc  <= next_acc;
			tick <= 1'b0;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	sequence s_quiet_after;
		!tick [*8];
	endsequence

	a_tick_single_pulse: assert property (
		@(posedge core_clk) disable iff (!rstn)
		tick |=> s_quiet_after
	) else $error("Low-speed tick pulses closer than expected.");

endmodule : lsclk_tick_gen

`default_nettype wire

// file: verilog/standby_wakeup_watchdog.sv
// What this block does
// - A 32-bit counter decrements once per 32.768 kHz tick.
// - Arriving at zero sets the status flag and raises the interrupt.
// - After zero the counter reloads from the reload value register.
// - An expiry while the previous flag is still set requests a reset.
// - Interrupt and flag stay set until software clears the flag.
// - Counting goes on in standby; an expiry there wakes the system.
// - Software may force a reload, restarting the full interval.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

module standby_wakeup_watchdog #(
	parameter int COUNT_W = `WDT_COUNT_W
) (
	// Clock and reset.
	input  wire logic                core_clk,
	input  wire logic                rstn,
	// Control from the system side.
	input  wire wdt_pkg::wdt_ctrl_s  ctrl,
	input  wire logic [COUNT_W-1:0]  reload_value_register,
	// Status toward the system.
	output var  wdt_pkg::wdt_stat_s  stat,
	output var  logic [COUNT_W-1:0]  count
);

	// ***************************************************************
	// Low-speed tick
	// ***************************************************************
	logic tick;

	lsclk_tick_gen u_tick (
		.core_clk (core_clk),
		.rstn     (rstn),
		.tick     (tick)
	);

	// ***************************************************************
	// Enable state
	// ***************************************************************
	wdt_pkg::wd_state_e state;

	// Leaving idle only needs the enable level; dropping it stops counting.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= wdt_pkg::st_idle;
		end else begin
			case (state)
				wdt_pkg::st_idle: begin
					if (ctrl.enable) begin
						state <= wdt_pkg::st_run;
					end
				end
				wdt_pkg::st_run: begin
					if (!ctrl.enable) begin
						state <= wdt_pkg::st_idle;
					end
				end
				default: begin
					state <= wdt_pkg::st_idle;
				end
			endcase
		end
	end

	// ***************************************************************
	// Down counter
	// ***************************************************************
	logic running;
	logic expire;
	logic status_flag;
	logic reset_req;
	logic wakeup;

	// A tick on a count of one, or of zero after a zero reload, ends the
	// interval; the checks reuse this so both sides agree on the end point.
	function automatic logic reaches_zero(input logic [COUNT_W-1:0] value);
		return value <= COUNT_W'(1);
	endfunction : reaches_zero

	// Standby is deliberately not a term here, so the count keeps going.
	assign running = (state == wdt_pkg::st_run);

	// A tick at count one (or zero after a zero reload) arrives at zero.
	assign expire = running && tick && !ctrl.force_reload
		&& reaches_zero(count);

	// A forced reload wins over a tick in the same cycle.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			count <= COUNT_W'(`WDT_COUNT_RST);
		end else if (!running || ctrl.force_reload) begin
			count <= reload_value_register;
		end else if (expire) begin
			count <= reload_value_register;
		end else if (tick) begin
			count <= count - COUNT_W'(1);
		end
	end

	// ***************************************************************
	// Status flag, reset request and wake-up
	// ***************************************************************
	// Set wins over clear so no expiry is ever lost.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_flag <= `WDT_FLAG_RST;
		end else if (expire) begin
			status_flag <= 1'b1;
		end else if (ctrl.clear_status) begin
			status_flag <= 1'b0;
		end
	end

	// A clear in the same cycle as the new expiry counts as serviced.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reset_req <= 1'b0;
		end else begin
			reset_req <= expire && status_flag
				&& !ctrl.clear_status;
		end
	end

	// Wake-up pulse for an expiry seen while the system sleeps.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wakeup <= 1'b0;
		end else begin
			wakeup <= expire && ctrl.standby;
		end
	end

	// Interrupt is the registered flag itself, so it cannot drop alone.
	// Gathering the word in one process gives each field one driver.
	always_comb begin
		stat.irq         = status_flag;
		stat.status_flag = status_flag;
		stat.wakeup      = wakeup;
		stat.reset_req   = reset_req;
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	sequence s_expiry;
		expire;
	endsequence

	sequence s_flag_raised;
		stat.irq && stat.status_flag;
	endsequence

	a_count_decrement: assert property (
		@(posedge core_clk) disable iff (!rstn)
		running && tick && !ctrl.force_reload && !reaches_zero(count)
		|=> count == $past(count) - COUNT_W'(1)
	) else $error("Counter did not decrement by one on a tick.");

	a_expiry_sets_flag: assert property (
		@(posedge core_clk) disable iff (!rstn)
		s_expiry |=> s_flag_raised
	) else $error("Expiry did not raise the flag and interrupt.");

	a_expiry_reloads: assert property (
		@(posedge core_clk) disable iff (!rstn)
		s_expiry |=> count == $past(reload_value_register)
	) else $error("Counter did not reload after arriving at zero.");

	a_second_expiry_rst: assert property (
		@(posedge core_clk) disable iff (!rstn)
		s_expiry ##0 (status_flag && !ctrl.clear_status)
		|=> stat.reset_req
	) else $error("Expiry on a pending flag gave no reset request.");

	a_reset_has_cause: assert property (
		@(posedge core_clk) disable iff (!rstn)
		stat.reset_req |-> $past(status_flag) && $past(expire)
	) else $error("Reset request without a pending second expiry.");

	a_flag_sticky: assert property (
		@(posedge core_clk) disable iff (!rstn)
		stat.irq && !ctrl.clear_status |=> stat.irq
	) else $error("Interrupt dropped without a software clear.");

	a_standby_wakeup: assert property (
		@(posedge core_clk) disable iff (!rstn)
		s_expiry ##0 ctrl.standby |=> stat.wakeup ##0 s_flag_raised
	) else $error("Expiry in standby did not wake the system.");

	a_force_reload: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl.force_reload |=> count == $past(reload_value_register)
			&& !stat.reset_req
	) else $error("Forced reload did not restart the interval.");

	a_idle_holds: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!running |-> !expire ##1 count == $past(reload_value_register)
	) else $error("Counter moved or expired while disabled.");

	a_clear_set_wins: assert property (
		@(posedge core_clk) disable iff (!rstn)
		s_expiry ##0 ctrl.clear_status |=> stat.status_flag && !stat.reset_req
	) else $error("Clear in an expiry cycle lost the flag.");

	a_clear_drops_flag: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl.clear_status && !expire |=> !stat.irq && !stat.status_flag
	) else $error("Software clear did not drop the flag.");

	a_wakeup_cause: assert property (
		@(posedge core_clk) disable iff (!rstn)
		stat.wakeup |-> $past(expire) && $past(ctrl.standby)
	) else $error("Wake-up pulse without an expiry in standby.");

	a_pulse_one_cycle: assert property (
		@(posedge core_clk) disable iff (!rstn)
		stat.reset_req || stat.wakeup |=> !stat.reset_req && !stat.wakeup
	) else $error("Reset request or wake-up stood longer than a cycle.");

endmodule : standby_wakeup_watchdog

`default_nettype wire

// file: verilog/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ***************************************************************
// Timing of the low-speed tick
// ***************************************************************
`define WDT_CORE_HZ    25000000
`define WDT_LSCLK_HZ   32768
`define WDT_ACC_W      25

// ***************************************************************
// Counter layout and reset values
// ***************************************************************
`define WDT_COUNT_W    32
`define WDT_COUNT_RST  32'h0000_0000
`define WDT_FLAG_RST   1'b0

`endif

// file: verilog/wdt_pkg.sv
`include "wdt_consts.svh"

package wdt_pkg;

	// Counter state, Gray coded along idle to run.
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_run  = 2'b01
	} wd_state_e;

	// Control levels and strobes from the system side.
	typedef struct packed {
		logic enable;
		logic force_reload;
		logic clear_status;
		logic standby;
	} wdt_ctrl_s;

	// Status outputs of the watchdog.
	typedef struct packed {
		logic irq;
		logic status_flag;
		logic wakeup;
		logic reset_req;
	} wdt_stat_s;

endpackage : wdt_pkg
